// [adc_scan_pkg.sv]
package adc_scan_pkg;
  // Register offsets (byte offsets within the control region)
  localparam logic [3:0] OFS_IRQ_FIFO   = 4'h0;
  localparam logic [3:0] OFS_SCAN_CFG   = 4'h2;
  localparam logic [3:0] OFS_ADC_STATUS = 4'h2;

  // Interrupt/FIFO register write fields
  localparam int IRQ_SRC_LO       = 0;
  localparam int GEN_IRQ_ENABLE   = 2;
  localparam int ACQ_IRQ_ENABLE   = 4;
  localparam int ACQ_CLEAR        = 6;
  localparam int GEN_CLEAR        = 7;
  localparam int OVF_CLEAR        = 13;

  // Interrupt/FIFO register read fields
  localparam int ACQ_STATUS       = 6;
  localparam int GEN_STATUS       = 7;
  localparam int BURST_STATUS     = 9;
  localparam int HALF_STATUS      = 10;
  localparam int NONEMPTY_LATCHED = 11;
  localparam int NONEMPTY_LIVE    = 12;
  localparam int OVF_STATUS       = 13;

  // Scan/config register fields
  localparam int START_CH_LO      = 0;
  localparam int STOP_CH_LO       = 4;
  localparam int GAIN_LO          = 8;
  localparam int SINGLE_ENDED     = 10;
  localparam int UNIPOLAR         = 11;
  localparam int PACER_LO         = 12;

  // FIFO half-full threshold and reset values
  localparam logic [9:0]  HALF_THRESHOLD = 10'h0ff;
  localparam logic [15:0] SCAN_CFG_RESET = 16'h0000;
  localparam logic [1:0]  IRQ_SRC_RESET  = 2'h0;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_SCAN_END,
    SRC_FIFO_HALF,
    SRC_FIFO_NONEMPTY
  } irq_src_e;

  typedef enum logic [1:0] {
    PACE_SOFTWARE,
    PACE_COUNTER,
    PACE_EXT_FALL,
    PACE_EXT_RISE
  } pacer_src_e;

  typedef enum logic [1:0] {
    GAIN_X1,
    GAIN_X2,
    GAIN_X4,
    GAIN_X8
  } gain_e;
endpackage : adc_scan_pkg

// [adc_scan_interrupt_status.sv]
`timescale 1ns/1ps
// Summary of operation
// R01: Control region takes 16-bit word reads and writes for control and status.
// R02: Source select 01 scan end, 10 half full, 11 not empty, 00 none.
// R03: Acquisition-done enable gates the FIFO acquisition-complete interrupt.
// R04: Clear bits act on one; zeros leave latches; no write-back needed.
// R05: Acquisition-done latch sets on event, holds until cleared.
// R06: General status latches selected event, zero until it happens.
// R07: Burst-done latch sets at burst end, meaningful only in burst mode.
// R08: Half-full latch sets once FIFO holds more than 255 words.
// R09: Not-empty latch sets on FIFO entry; zero when emptied or busy.
// R10: Live not-empty bit shows at least one word waiting.
// R11: Overflow latch sets on write into full FIFO until cleared.
// R12: Scan write loads start channel; advance per conversion, wrap after stop.
// R13: Start channel bits 3..0, stop channel bits 7..4, 4-bit binary.
// R14: Gain code 00..11 selects gain 1, 2, 4, 8.
// R15: Single-ended bit one gives 16 channels, zero gives 8 differential.
// R16: Unipolar bit one selects unipolar, zero bipolar range.
// R17: Pacer field: software, counter, external falling, external rising.
// R18: Host starts software conversions by word write to data region start.
// R19: General enable gates selected source onto interrupt request.
// R20: Clear bits reset general, acquisition and overflow latches.
// R21: Interrupt register reads status only; reads clear nothing.
module adc_scan_interrupt_status #(
  parameter int FIFO_COUNT_W = 10
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [3:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  output logic      [15:0]             reg_rdata,
  input  wire logic                    sw_convert_wr,
  input  wire logic                    conv_done,
  input  wire logic                    conv_busy,
  input  wire logic                    fifo_write,
  input  wire logic                    fifo_full,
  input  wire logic [FIFO_COUNT_W-1:0] fifo_count,
  input  wire logic                    acquisition_done,
  input  wire logic                    burst_done,
  input  wire logic                    burst_enable,
  output logic      [3:0]              mux_channel,
  output logic      [1:0]              gain_sel,
  output logic                         single_ended_sel,
  output logic                         unipolar_sel,
  output logic      [1:0]              pacer_source_sel,
  output logic                         sw_convert,
  output logic                         irq
);

  logic [1:0]  irq_src;
  logic        gen_irq_en;
  logic        acq_done_irq_enable;
  logic        acq_done_status;
  logic        general_status;
  logic        burst_done_status;
  logic        fifo_half_latched;
  logic        fifo_nonempty_latched;
  logic        fifo_overflow_latched;
  logic [3:0]  scan_start_channel;
  logic [3:0]  scan_stop_channel;
  logic        wr_irq;
  logic        wr_scan;
  logic        fifo_nonempty_live;
  logic        fifo_half_now;
  logic        scan_end;
  logic        sel_event;
  logic        acq_done_clear;
  logic        general_irq_clear;
  logic        fifo_overflow_clear;
  logic [15:0] next_rdata;

  assign wr_irq  = reg_wr && (reg_addr == adc_scan_pkg::OFS_IRQ_FIFO); // R01
  assign wr_scan = reg_wr && (reg_addr == adc_scan_pkg::OFS_SCAN_CFG); // R01
  assign acq_done_clear      = wr_irq && reg_wdata[adc_scan_pkg::ACQ_CLEAR]; // R04
  assign general_irq_clear   = wr_irq && reg_wdata[adc_scan_pkg::GEN_CLEAR]; // R04
  assign fifo_overflow_clear = wr_irq && reg_wdata[adc_scan_pkg::OVF_CLEAR]; // R04
  assign fifo_nonempty_live  = (fifo_count != '0); // R10
  assign fifo_half_now = fifo_count > FIFO_COUNT_W'(adc_scan_pkg::HALF_THRESHOLD); // R08
  assign scan_end = conv_done && (mux_channel == scan_stop_channel);

  always_comb begin
    case (adc_scan_pkg::irq_src_e'(irq_src)) // R02
      adc_scan_pkg::SRC_SCAN_END:      sel_event = scan_end;
      adc_scan_pkg::SRC_FIFO_HALF:     sel_event = fifo_half_now;
      adc_scan_pkg::SRC_FIFO_NONEMPTY: sel_event = fifo_nonempty_live;
      default:                         sel_event = 1'b0;
    endcase
  end

  // Control bits of the interrupt register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_src             <= adc_scan_pkg::IRQ_SRC_RESET;
      gen_irq_en          <= 1'b0;
      acq_done_irq_enable <= 1'b0;
    end else if (wr_irq) begin
      irq_src             <= reg_wdata[adc_scan_pkg::IRQ_SRC_LO +: 2];
      gen_irq_en          <= reg_wdata[adc_scan_pkg::GEN_IRQ_ENABLE];
      acq_done_irq_enable <= reg_wdata[adc_scan_pkg::ACQ_IRQ_ENABLE]; // R03
    end
  end

  // Sticky latches: set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_done_status       <= 1'b0;
      general_status        <= 1'b0;
      fifo_overflow_latched <= 1'b0;
    end else begin
      if (acquisition_done)
        acq_done_status <= 1'b1; // R05
      else if (acq_done_clear)
        acq_done_status <= 1'b0; // R20
      if (sel_event)
        general_status <= 1'b1; // R06
      else if (general_irq_clear)
        general_status <= 1'b0; // R20
      if (fifo_write && fifo_full)
        fifo_overflow_latched <= 1'b1; // R11
      else if (fifo_overflow_clear)
        fifo_overflow_latched <= 1'b0; // R20
    end
  end

  // FIFO related latches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_done_status     <= 1'b0;
      fifo_half_latched     <= 1'b0;
      fifo_nonempty_latched <= 1'b0;
    end else begin
      if (burst_enable && burst_done)
        burst_done_status <= 1'b1; // R07
      else if (general_irq_clear)
        burst_done_status <= 1'b0;
      if (fifo_half_now)
        fifo_half_latched <= 1'b1; // R08
      else if (general_irq_clear || !fifo_nonempty_live)
        fifo_half_latched <= 1'b0;
      if (fifo_write && !fifo_full)
        fifo_nonempty_latched <= 1'b1; // R09
      else if (!fifo_nonempty_live || conv_busy)
        fifo_nonempty_latched <= 1'b0; // R09
    end
  end

  // Scan configuration register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_start_channel <= adc_scan_pkg::SCAN_CFG_RESET[3:0];
      scan_stop_channel  <= adc_scan_pkg::SCAN_CFG_RESET[7:4];
      gain_sel           <= adc_scan_pkg::SCAN_CFG_RESET[9:8];
      single_ended_sel   <= adc_scan_pkg::SCAN_CFG_RESET[10];
      unipolar_sel       <= adc_scan_pkg::SCAN_CFG_RESET[11];
      pacer_source_sel   <= adc_scan_pkg::SCAN_CFG_RESET[13:12];
    end else if (wr_scan) begin
      scan_start_channel <= reg_wdata[adc_scan_pkg::START_CH_LO +: 4]; // R13
      scan_stop_channel  <= reg_wdata[adc_scan_pkg::STOP_CH_LO +: 4]; // R13
      gain_sel           <= reg_wdata[adc_scan_pkg::GAIN_LO +: 2]; // R14
      single_ended_sel   <= reg_wdata[adc_scan_pkg::SINGLE_ENDED]; // R15
      unipolar_sel       <= reg_wdata[adc_scan_pkg::UNIPOLAR]; // R16
      pacer_source_sel   <= reg_wdata[adc_scan_pkg::PACER_LO +: 2]; // R17
    end
  end

  // Multiplexer sequencing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      mux_channel <= 4'h0;
    else if (wr_scan)
      mux_channel <= reg_wdata[adc_scan_pkg::START_CH_LO +: 4]; // R12
    else if (conv_done) begin
      if (mux_channel == scan_stop_channel)
        mux_channel <= scan_start_channel; // R12
      else
        mux_channel <= mux_channel + 4'h1; // R12
    end
  end

  // Software conversion start pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      sw_convert <= 1'b0;
    else
      sw_convert <= sw_convert_wr &&
                    (pacer_source_sel == adc_scan_pkg::PACE_SOFTWARE); // R17 R18
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= (gen_irq_en && general_status) ||
             (acq_done_irq_enable && acq_done_status); // R19 R03
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_addr == adc_scan_pkg::OFS_IRQ_FIFO) begin // R21
      next_rdata[adc_scan_pkg::ACQ_STATUS]       = acq_done_status;
      next_rdata[adc_scan_pkg::GEN_STATUS]       = general_status;
      next_rdata[adc_scan_pkg::BURST_STATUS]     = burst_done_status;
      next_rdata[adc_scan_pkg::HALF_STATUS]      = fifo_half_latched;
      next_rdata[adc_scan_pkg::NONEMPTY_LATCHED] = fifo_nonempty_latched;
      next_rdata[adc_scan_pkg::NONEMPTY_LIVE]    = fifo_nonempty_live; // R10
      next_rdata[adc_scan_pkg::OVF_STATUS]       = fifo_overflow_latched;
    end else if (reg_addr == adc_scan_pkg::OFS_ADC_STATUS) begin
      next_rdata[14] = !conv_busy;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= next_rdata; // R01
  end

  property p_overflow_set;
    @(posedge sys_clk) disable iff (!rst_n)
      (fifo_write && fifo_full) |=> fifo_overflow_latched;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("overflow not latched"); // R11

  property p_overflow_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (fifo_overflow_latched && !fifo_overflow_clear) |=> fifo_overflow_latched;
  endproperty
  a_overflow_hold: assert property (p_overflow_hold) else $error("overflow lost"); // R04

  property p_acq_set;
    @(posedge sys_clk) disable iff (!rst_n)
      acquisition_done |=> acq_done_status;
  endproperty
  a_acq_set: assert property (p_acq_set) else $error("acq done not latched"); // R05

  property p_acq_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (acq_done_clear && !acquisition_done) |=> !acq_done_status;
  endproperty
  a_acq_clear: assert property (p_acq_clear) else $error("acq clear failed"); // R20

  property p_general_set;
    @(posedge sys_clk) disable iff (!rst_n)
      sel_event |=> general_status;
  endproperty
  a_general_set: assert property (p_general_set) else $error("general not latched"); // R06

  property p_irq_gate;
    @(posedge sys_clk) disable iff (!rst_n)
      (!gen_irq_en && !acq_done_irq_enable) |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated"); // R19

  property p_half;
    @(posedge sys_clk) disable iff (!rst_n)
      (fifo_count > FIFO_COUNT_W'(adc_scan_pkg::HALF_THRESHOLD)) |=> fifo_half_latched;
  endproperty
  a_half: assert property (p_half) else $error("half full missed"); // R08

  property p_scan_load;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_scan |=> (mux_channel == $past(reg_wdata[3:0]));
  endproperty
  a_scan_load: assert property (p_scan_load) else $error("start channel not loaded"); // R12

  property p_scan_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (conv_done && !wr_scan && mux_channel == scan_stop_channel)
        |=> (mux_channel == $past(scan_start_channel));
  endproperty
  a_scan_wrap: assert property (p_scan_wrap) else $error("scan wrap wrong"); // R12

  property p_scan_step;
    @(posedge sys_clk) disable iff (!rst_n)
      (conv_done && !wr_scan && mux_channel != scan_stop_channel)
        |=> (mux_channel == $past(mux_channel) + 4'h1);
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("scan step wrong"); // R12

  property p_overflow_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (fifo_overflow_clear && !(fifo_write && fifo_full)) |=> !fifo_overflow_latched;
  endproperty
  a_overflow_clear: assert property (p_overflow_clear) else $error("overflow clear failed"); // R20

  property p_general_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (general_irq_clear && !sel_event) |=> !general_status;
  endproperty
  a_general_clear: assert property (p_general_clear) else $error("general clear failed"); // R20

  property p_general_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (general_status && !general_irq_clear) |=> general_status;
  endproperty
  a_general_hold: assert property (p_general_hold) else $error("general lost"); // R06

  property p_acq_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (acq_done_status && !acq_done_clear) |=> acq_done_status;
  endproperty
  a_acq_hold: assert property (p_acq_hold) else $error("acq done lost"); // R05

  property p_burst_set;
    @(posedge sys_clk) disable iff (!rst_n)
      (burst_enable && burst_done) |=> burst_done_status;
  endproperty
  a_burst_set: assert property (p_burst_set) else $error("burst done not latched"); // R07

  property p_nonempty_set;
    @(posedge sys_clk) disable iff (!rst_n)
      (fifo_write && !fifo_full) |=> fifo_nonempty_latched;
  endproperty
  a_nonempty_set: assert property (p_nonempty_set) else $error("nonempty not latched"); // R09

  property p_nonempty_drop;
    @(posedge sys_clk) disable iff (!rst_n)
      (!fifo_nonempty_live && !fifo_write) |=> !fifo_nonempty_latched;
  endproperty
  a_nonempty_drop: assert property (p_nonempty_drop) else $error("nonempty not dropped"); // R09

  property p_gain_load;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_scan |=> (gain_sel == $past(reg_wdata[adc_scan_pkg::GAIN_LO +: 2]));
  endproperty
  a_gain_load: assert property (p_gain_load) else $error("gain not loaded"); // R14

  property p_sw_convert;
    @(posedge sys_clk) disable iff (!rst_n)
      (sw_convert_wr && pacer_source_sel == adc_scan_pkg::PACE_SOFTWARE) |=> sw_convert;
  endproperty
  a_sw_convert: assert property (p_sw_convert) else $error("soft start missed"); // R17

  property p_sw_gate;
    @(posedge sys_clk) disable iff (!rst_n)
      (pacer_source_sel != adc_scan_pkg::PACE_SOFTWARE) |=> !sw_convert;
  endproperty
  a_sw_gate: assert property (p_sw_gate) else $error("soft start not gated"); // R17

  property p_acq_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      (acq_done_irq_enable && acq_done_status) |=> irq;
  endproperty
  a_acq_irq: assert property (p_acq_irq) else $error("acq irq missing"); // R03

  property p_read_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == adc_scan_pkg::OFS_IRQ_FIFO)
        |=> (reg_rdata[5:0] == 6'h00 && !reg_rdata[8] && reg_rdata[15:14] == 2'h0);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unused bits not zero"); // R21

  c_overflow: cover property (@(posedge sys_clk) disable iff (!rst_n)
    fifo_overflow_latched ##1 fifo_overflow_clear ##1 !fifo_overflow_latched);
  c_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n) scan_end);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq));
  c_acq: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(acq_done_status));
  c_swconv: cover property (@(posedge sys_clk) disable iff (!rst_n) sw_convert);

endmodule : adc_scan_interrupt_status

// [host_model.sv]
`timescale 1ns/1ps
module host_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] reg_rdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             sw_convert_wr
);
  initial begin
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_addr      = 4'h0;
    reg_wdata     = 16'h0000;
    sw_convert_wr = 1'b0;
  end

  // One whole word per strobe; data inverted once released
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
    @(negedge sys_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  // Word write to data region start; value is don't-care
  task automatic sw_conv();
    sw_convert_wr = 1'b1;
    @(negedge sys_clk);
    sw_convert_wr = 1'b0;
  endtask : sw_conv
endmodule : host_model

// [adc_scan_interrupt_status_tb.sv]
`timescale 1ns/1ps
module adc_scan_interrupt_status_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        reg_wr, reg_rd, sw_convert_wr, sw_convert, irq;
  logic        conv_busy = 1'b0, fifo_full = 1'b0, burst_enable = 1'b0;
  logic        single_ended_sel, unipolar_sel;
  logic [3:0]  reg_addr, mux_channel;
  logic [3:0]  evs = 4'h0;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [9:0]  fifo_count = 10'h000;
  logic [1:0]  gain_sel, pacer_source_sel;
  int          failures = 0, comparisons = 0;

  always #25 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .sw_convert_wr(sw_convert_wr));

  adc_scan_interrupt_status uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sw_convert_wr(sw_convert_wr), .conv_done(evs[0]), .conv_busy(conv_busy),
    .fifo_write(evs[1]), .fifo_full(fifo_full), .fifo_count(fifo_count),
    .acquisition_done(evs[2]), .burst_done(evs[3]), .burst_enable(burst_enable),
    .mux_channel(mux_channel), .gain_sel(gain_sel), .single_ended_sel(single_ended_sel),
    .unipolar_sel(unipolar_sel), .pacer_source_sel(pacer_source_sel),
    .sw_convert(sw_convert), .irq(irq));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Event pulses: 0 conversion, 1 FIFO push, 2 acquisition, 3 burst
  task automatic ev(input int k, input int n);
    repeat (n) begin
      evs[k] = 1'b1;
      @(negedge sys_clk);
      evs = 4'h0;
      @(negedge sys_clk);
    end
  endtask : ev

  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    host.rd(a, d);
    chk("rdata", d, e);
  endtask : rchk

  initial begin
    #3000000;
    failures++;
    summarize();
  end

  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("irq", {15'h0, irq}, 16'h0000);
    rchk(4'h0, 16'h0000);
    host.wr(4'h2, 16'h1f53);
    chk("mux", {12'h0, mux_channel}, 16'h0003);
    chk("se", {15'h0, single_ended_sel}, 16'h0001);
    chk("uni", {15'h0, unipolar_sel}, 16'h0001);
    rchk(4'h2, 16'h4000);
    for (int i = 0; i < 4; i++) begin
      host.wr(4'h2, {2'h0, 2'(i), 2'h0, 2'(i), 8'h53});
      chk("gain", {14'h0, gain_sel}, 16'(i));
      chk("pacer", {14'h0, pacer_source_sel}, 16'(i));
      chk("se0", {14'h0, single_ended_sel, unipolar_sel}, 16'h0000);
    end
    host.wr(4'h2, 16'h0053);
    host.wr(4'h0, 16'h0005);
    ev(0, 2);
    chk("mux", {12'h0, mux_channel}, 16'h0005);
    rchk(4'h0, 16'h0000);
    ev(0, 1);
    chk("mux", {12'h0, mux_channel}, 16'h0003);
    rchk(4'h0, 16'h0080);
    chk("irq", {15'h0, irq}, 16'h0001);
    host.wr(4'h0, 16'h0005);
    rchk(4'h0, 16'h0080);
    host.wr(4'h0, 16'h0085);
    rchk(4'h0, 16'h0000);
    chk("irq", {15'h0, irq}, 16'h0000);
    host.wr(4'h0, 16'h0001);
    ev(0, 3);
    rchk(4'h0, 16'h0080);
    chk("irq", {15'h0, irq}, 16'h0000);
    host.wr(4'h0, 16'h0087);
    fifo_count = 10'h001;
    ev(1, 1);
    rchk(4'h0, 16'h1880);
    chk("irq", {15'h0, irq}, 16'h0001);
    fifo_count = 10'h000;
    host.wr(4'h0, 16'h0086);
    fifo_count = adc_scan_pkg::HALF_THRESHOLD;
    ev(1, 1);
    rchk(4'h0, 16'h1800);
    fifo_count = adc_scan_pkg::HALF_THRESHOLD + 10'h001;
    ev(1, 1);
    rchk(4'h0, 16'h1c80);
    fifo_count = 10'h000;
    @(negedge sys_clk);
    rchk(4'h0, 16'h0080);
    host.wr(4'h0, 16'h0084);
    ev(0, 3);
    rchk(4'h0, 16'h0000);
    chk("irq", {15'h0, irq}, 16'h0000);
    conv_busy  = 1'b1;
    fifo_count = 10'h001;
    ev(1, 1);
    rchk(4'h0, 16'h1000);
    rchk(4'h2, 16'h0000);
    conv_busy  = 1'b0;
    fifo_count = 10'h000;
    host.wr(4'h0, 16'h0010);
    ev(2, 1);
    rchk(4'h0, 16'h0040);
    chk("irq", {15'h0, irq}, 16'h0001);
    host.wr(4'h0, 16'h0010);
    rchk(4'h0, 16'h0040);
    host.wr(4'h0, 16'h0050);
    rchk(4'h0, 16'h0000);
    chk("irq", {15'h0, irq}, 16'h0000);
    host.wr(4'h0, 16'h0000);
    ev(2, 1);
    rchk(4'h0, 16'h0040);
    chk("irq", {15'h0, irq}, 16'h0000);
    host.wr(4'h0, 16'h0040);
    burst_enable = 1'b1;
    ev(3, 1);
    rchk(4'h0, 16'h0200);
    host.wr(4'h0, 16'h0080);
    rchk(4'h0, 16'h0000);
    fifo_full  = 1'b1;
    fifo_count = 10'h200;
    ev(1, 1);
    rchk(4'h0, 16'h3400);
    fifo_full  = 1'b0;
    fifo_count = 10'h000;
    @(negedge sys_clk);
    rchk(4'h0, 16'h2000);
    host.wr(4'h0, 16'h2000);
    rchk(4'h0, 16'h0000);
    host.sw_conv();
    chk("swconv", {15'h0, sw_convert}, 16'h0001);
    @(negedge sys_clk);
    chk("swconv", {15'h0, sw_convert}, 16'h0000);
    host.wr(4'h2, 16'h1053);
    host.sw_conv();
    chk("swconv", {15'h0, sw_convert}, 16'h0000);
    rchk(4'h6, 16'h0000);
    host.wr(4'h6, 16'hffff);
    rchk(4'h0, 16'h0000);
    chk("pacer", {14'h0, pacer_source_sel}, 16'h0001);
    summarize();
  end
endmodule : adc_scan_interrupt_status_tb
